/* pkg/sramc_pkg.sv */
`default_nettype none
package sramc_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;

  // ==========================================================
  // timing, figures in ns at the fastest grade
  localparam int CLK_PERIOD_NS             = 8;
  localparam int SELECT_TO_VALID_DELAY_NS  = 180;
  localparam int OUTPUT_ENABLE_DELAY_NS    = 130;
  localparam int OUTPUT_FLOAT_DELAY_NS     = 180;
  localparam int SELECT_TO_WRITE_END_MIN_NS = 150;
  localparam int ADDR_HOLD_NS              = 40;

  // least times round up
  localparam int SEL_VALID_CYC = (SELECT_TO_VALID_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_VALID_CYC  = (OUTPUT_ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC     = (OUTPUT_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_SEL_CYC    = (SELECT_TO_WRITE_END_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  // read wait is the later of select and output-enable delays
  localparam int RD_WAIT_CYC = (SEL_VALID_CYC > OE_VALID_CYC) ? SEL_VALID_CYC : OE_VALID_CYC;

  // ==========================================================
  // reset values of the pins
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SRAMC_IDLE,
    SRAMC_READ,
    SRAMC_WRITE,
    SRAMC_FLOAT
  } sramc_state_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sramc_req_t;

endpackage
`default_nettype wire

/* rtl/sramc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - shared data pins, host drives only writes
// - two active-low chip selects per package
// - wait select-to-valid delay before sampling read
// - wait output-enable delay before sampling read
// - hold selects before write end long enough
module sramc_host #(
  parameter int ADDR_W = sramc_pkg::ADDR_W,
  parameter int DATA_W = sramc_pkg::DATA_W
) (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_B,
  input  wire sramc_pkg::sramc_req_t REQ,
  input  wire logic                 REQ_VALID,
  output var  logic                 REQ_READY,
  output var  logic [DATA_W-1:0]    RDATA,
  output var  logic                 RDATA_VALID,
  output var  logic [ADDR_W-1:0]    MEM_ADDR,
  output var  logic                 CHIP_SELECT_FIRST_N,
  output var  logic                 CHIP_SELECT_SECOND_N,
  output var  logic                 OUTPUT_DISABLE,
  output var  logic                 WRITE_N,
  input  wire logic [DATA_W-1:0]    MEM_DATA_I,
  output var  logic [DATA_W-1:0]    MEM_DATA_O,
  output var  logic [DATA_W-1:0]    MEM_DATA_OE_N
);

  // ==========================================================
  // pin input synchroniser
  logic [DATA_W-1:0] din_meta_reg;
  logic [DATA_W-1:0] din_sync_reg;

  // two stages; the first feeds only the second
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      din_meta_reg <= sramc_pkg::DATA_RST;
      din_sync_reg <= sramc_pkg::DATA_RST;
    end else begin
      din_meta_reg <= MEM_DATA_I;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ==========================================================
  // sequencer
  sramc_pkg::sramc_state_t        state_reg;
  logic [sramc_pkg::CNT_W-1:0]    cnt_reg;

  // read waits two extra cycles for the synchroniser
  localparam logic [sramc_pkg::CNT_W-1:0] RD_WAIT =
    sramc_pkg::CNT_W'(sramc_pkg::RD_WAIT_CYC + 2);
  localparam logic [sramc_pkg::CNT_W-1:0] WR_WAIT =
    sramc_pkg::CNT_W'(sramc_pkg::WR_SEL_CYC);
  localparam logic [sramc_pkg::CNT_W-1:0] FL_WAIT =
    sramc_pkg::CNT_W'(sramc_pkg::FLOAT_CYC);

  // ==========================================================
  // access decode
  logic                           accept;
  logic                           rd_done;
  logic                           wr_done;
  logic                           fl_done;

  // start and end of each phase, decoded once so the pin processes agree
  always_comb begin
    accept  = (state_reg == sramc_pkg::SRAMC_IDLE) && REQ_VALID && REQ_READY;
    rd_done = (state_reg == sramc_pkg::SRAMC_READ) && (cnt_reg == RD_WAIT);
    wr_done = (state_reg == sramc_pkg::SRAMC_WRITE) && (cnt_reg == WR_WAIT);
    fl_done = (state_reg == sramc_pkg::SRAMC_FLOAT) && (cnt_reg == FL_WAIT);
  end

  // state walk; a read always passes through float before the bus is reused
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= sramc_pkg::SRAMC_IDLE;
    end else begin
      case (state_reg)
        sramc_pkg::SRAMC_IDLE: begin
          if (accept) begin
            state_reg <= REQ.write ? sramc_pkg::SRAMC_WRITE : sramc_pkg::SRAMC_READ;
          end
        end
        sramc_pkg::SRAMC_READ: begin
          if (rd_done) begin
            state_reg <= sramc_pkg::SRAMC_FLOAT;
          end
        end
        sramc_pkg::SRAMC_WRITE: begin
          if (wr_done) begin
            state_reg <= sramc_pkg::SRAMC_IDLE;
          end
        end
        sramc_pkg::SRAMC_FLOAT: begin
          if (fl_done) begin
            state_reg <= sramc_pkg::SRAMC_IDLE;
          end
        end
        default: begin
          state_reg <= sramc_pkg::SRAMC_IDLE;
        end
      endcase
    end
  end

  // cycle counter, restarted at each phase end so every wait counts from zero
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_reg <= '0;
    end else if (state_reg == sramc_pkg::SRAMC_IDLE) begin
      cnt_reg <= '0;
    end else if (rd_done || wr_done || fl_done) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // request handshake
  // ready only in idle, registered so it leaves with the accept
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      REQ_READY <= 1'b0;
    end else if (state_reg == sramc_pkg::SRAMC_IDLE) begin
      REQ_READY <= !accept;
    end else begin
      REQ_READY <= 1'b0;
    end
  end

  // ==========================================================
  // address, latched for the whole access so the word never moves under a read
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_ADDR <= sramc_pkg::ADDR_RST;
    end else if (accept) begin
      MEM_ADDR <= REQ.addr;
    end
  end

  // both selects move together, so any package on the bus sees one decode
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CHIP_SELECT_FIRST_N  <= 1'b1;
      CHIP_SELECT_SECOND_N <= 1'b1;
    end else if (accept) begin
      CHIP_SELECT_FIRST_N  <= 1'b0;
      CHIP_SELECT_SECOND_N <= 1'b0;
    end else if (rd_done || wr_done) begin
      CHIP_SELECT_FIRST_N  <= 1'b1;
      CHIP_SELECT_SECOND_N <= 1'b1;
    end
  end

  // ==========================================================
  // output disable, held high except during reads, so a write never meets memory drive
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      OUTPUT_DISABLE <= 1'b1;
    end else if (accept) begin
      OUTPUT_DISABLE <= REQ.write;
    end else if (rd_done || wr_done) begin
      OUTPUT_DISABLE <= 1'b1;
    end
  end

  // write strobe spans the select window; selects and strobe end together
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WRITE_N <= 1'b1;
    end else if (accept) begin
      WRITE_N <= !REQ.write;
    end else if (wr_done) begin
      WRITE_N <= 1'b1;
    end
  end

  // ==========================================================
  // write data; only meaningful while the pin enable below is low
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_DATA_O <= sramc_pkg::DATA_RST;
    end else if (accept && REQ.write) begin
      MEM_DATA_O <= REQ.wdata;
    end
  end

  // pins driven only while writing; zero hold needed, release with strobe
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_DATA_OE_N <= '1;
    end else if (accept && REQ.write) begin
      MEM_DATA_OE_N <= '0;
    end else if (wr_done) begin
      MEM_DATA_OE_N <= '1;
    end
  end

  // ==========================================================
  // read word, held until the next read; memory needs no refresh or clock
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= sramc_pkg::DATA_RST;
    end else if (rd_done) begin
      RDATA <= din_sync_reg;
    end
  end

  // one-cycle strobe alongside the word
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= rd_done;
    end
  end

endmodule
`default_nettype wire

/* dv/sramc_host_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// pin protocol checks
module sramc_host_checker (
  input wire logic       CORE_CLK,
  input wire logic       RST_B,
  input wire logic       RDATA_VALID,
  input wire logic [7:0] MEM_ADDR,
  input wire logic       CHIP_SELECT_FIRST_N,
  input wire logic       CHIP_SELECT_SECOND_N,
  input wire logic       OUTPUT_DISABLE,
  input wire logic       WRITE_N,
  input wire logic [3:0] MEM_DATA_OE_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  a_selects_paired: assert property (CHIP_SELECT_FIRST_N == CHIP_SELECT_SECOND_N)
    else $error("selects differ");
  a_drive_on_write: assert property (MEM_DATA_OE_N != 4'hF |-> !WRITE_N && OUTPUT_DISABLE)
    else $error("host drives outside a write");
  a_select_wait: assert property (RDATA_VALID |-> !$past(CHIP_SELECT_FIRST_N, 23))
    else $error("read taken too early after select");
  a_enable_wait: assert property (RDATA_VALID |-> !$past(OUTPUT_DISABLE, 17))
    else $error("read taken too early after enable");
  a_addr_held: assert property (!CHIP_SELECT_FIRST_N && !$past(CHIP_SELECT_FIRST_N)
    |-> $stable(MEM_ADDR)) else $error("address moved in access");
  a_write_select: assert property ($rose(WRITE_N) |-> !$past(CHIP_SELECT_FIRST_N, 19))
    else $error("select too short before write end");
  a_strobe_selected: assert property (!WRITE_N |-> !CHIP_SELECT_SECOND_N)
    else $error("strobe without select");
  // 22 samples after the read ends is 23 cycles from release, past the float time
  a_float_gap: assert property ($rose(OUTPUT_DISABLE)
    |-> ##22 (CHIP_SELECT_FIRST_N && MEM_DATA_OE_N == 4'hF))
    else $error("bus reused before float");
endmodule
bind sramc_host sramc_host_checker u_chk (.CORE_CLK, .RST_B, .RDATA_VALID, .MEM_ADDR,
  .CHIP_SELECT_FIRST_N, .CHIP_SELECT_SECOND_N, .OUTPUT_DISABLE, .WRITE_N, .MEM_DATA_OE_N);
`default_nettype wire

/* dv/sramc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// behavioural 256x4 memory, access time counted in clocks
module sramc_mem_model #(
  parameter int LAT = sramc_pkg::RD_WAIT_CYC // slowest legal answer, so an early sample fails
) (
  input wire logic       clk,
  input wire logic [7:0] addr,
  input wire logic       sel1_n,
  input wire logic       sel2_n,
  input wire logic       out_dis,
  input wire logic       wr_n,
  input wire logic [3:0] din,
  output logic [3:0]     dout
);
  logic [3:0] mem [256];
  logic [3:0] last_reg = 4'h5;
  int         cnt = 0;
  wire        sel = !sel1_n && !sel2_n;
  // store while strobed and selected
  always @(posedge clk) if (sel && !wr_n) mem[addr] <= din;
  // data valid only once enabled long enough
  always @(posedge clk) begin
    cnt <= (sel && !out_dis && wr_n) ? cnt + 1 : 0;
    if (cnt >= LAT) last_reg <= mem[addr];
  end
  // released bus shows the inverted last word, not a stale copy
  assign dout = (cnt >= LAT && sel && !out_dis) ? mem[addr] : ~last_reg;
endmodule
`default_nettype wire

/* dv/sramc_host_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// self-checking bench
module sramc_host_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic vld = 1'b0;
  sramc_pkg::sramc_req_t req = '0;
  logic [3:0] rdata, mdi, mdo, oe_n;
  logic [7:0] maddr;
  logic rdy, rvld, cs1_n, cs2_n, od, wr_n;
  int n_errors = 0;
  int comparisons = 0;
  // host drives a bit only while its enable is low
  wire logic [3:0] bus = (~oe_n & mdo) | (oe_n & mdi);
  always #4 clk = ~clk;
  sramc_host DUT (.CORE_CLK(clk), .RST_B(rst_b), .REQ(req), .REQ_VALID(vld),
    .REQ_READY(rdy), .RDATA(rdata), .RDATA_VALID(rvld), .MEM_ADDR(maddr),
    .CHIP_SELECT_FIRST_N(cs1_n), .CHIP_SELECT_SECOND_N(cs2_n), .OUTPUT_DISABLE(od),
    .WRITE_N(wr_n), .MEM_DATA_I(bus), .MEM_DATA_O(mdo), .MEM_DATA_OE_N(oe_n));
  sramc_mem_model mem (.clk(clk), .addr(maddr), .sel1_n(cs1_n), .sel2_n(cs2_n),
    .out_dis(od), .wr_n(wr_n), .din(bus), .dout(mdi));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one request; a read also judges latency and data
  task automatic op(input logic w, input logic [7:0] a, input logic [3:0] d);
    int n;
    req <= '{w, a, d};
    vld <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 200);
    vld <= 1'b0;
    if (!w) begin
      n = 0;
      do begin @(posedge clk); n++; end while (rvld !== 1'b1 && n < 100);
      check(8'(n), 8'(sramc_pkg::RD_WAIT_CYC + 4));
      check({4'h0, rdata}, {4'h0, d});
    end
    @(posedge clk);
  endtask
  // pins parked while reset is held
  task automatic reset_values();
    check({7'h0, od}, 8'h01);
    check({cs1_n, cs2_n, wr_n, rdy, oe_n}, 8'hEF);
  endtask
  // end addresses, written then read back in reverse, one read twice, then write after read
  task automatic corners();
    logic [7:0] a [4] = '{8'h00, 8'hFF, 8'h80, 8'h7F};
    for (int i = 0; i < 4; i++) op(1'b1, a[i], 4'(i * 5 + 3));
    for (int i = 3; i >= 0; i--) op(1'b0, a[i], 4'(i * 5 + 3));
    op(1'b0, 8'h00, 4'h3);
    op(1'b1, 8'h80, 4'hC);
    op(1'b0, 8'h80, 4'hC);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_values();
    rst_b <= 1'b1;
    @(posedge clk);
    corners();
    report_and_stop();
  end
  // hang guard, far beyond eleven accesses
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
